/* verif/frs_chk.sv */
// Port checker for the fault response sequencer
`timescale 1ns/1ns
`default_nettype none
module frs_chk #(
  parameter int OPER_UNIT_CYC  = frs_pkg::OPER_UNIT_CYC,
  parameter int RETRY_UNIT_CYC = frs_pkg::RETRY_UNIT_CYC
) (
  // Clock, reset, host
  input wire logic              sys_clk,
  input wire logic              sys_rst,
  input wire frs_pkg::frs_req_s req,
  input wire logic [15:0]       rd_data_ff,
  input wire logic              rd_valid_ff,
  input wire logic              clear_faults,
  // Power stage and alert
  input wire logic              uc_fault,
  input wire logic [15:0]       temperature,
  input wire logic              output_cmd_on,
  input wire logic              output_enable_ff,
  input wire logic              alert_line_n_ff
);
  logic [7:0] act_ff;
  logic [7:0] nxt_act;
  always_comb nxt_act = (req.wr && req.cmd == frs_pkg::CMD_UC_ACTION) ? req.data[7:0] : act_ff;
  always_ff @(posedge sys_clk) act_ff <= sys_rst ? frs_pkg::ACTION_RST : nxt_act;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  a_read_answer: assert property (req.rd |=> rd_valid_ff) else $error("read not answered");
  a_read_cause: assert property (rd_valid_ff |-> $past(req.rd)) else $error("stray read valid");
  a_fault_alert: assert property (uc_fault |=> !alert_line_n_ff) else $error("alert not raised");
  a_alert_sticky: assert property (!alert_line_n_ff && !clear_faults |=> !alert_line_n_ff) else $error("alert lost");
  a_ignore_runs: assert property (act_ff[7:6] == 2'h0 && output_enable_ff && output_cmd_on |=> output_enable_ff)
    else $error("ignore mode dropped output");
  a_retry_drop: assert property (act_ff[7:6] == 2'h2 && uc_fault && output_enable_ff |=> !output_enable_ff)
    else $error("output not disabled");
  a_hold_drop: assert property (act_ff[7:6] == 2'h3 && uc_fault |=> !output_enable_ff) else $error("hold mode on");
  a_delay_runs: assert property (act_ff[7:6] == 2'h1 && act_ff[2:0] != 3'h0 && $rose(uc_fault) && output_enable_ff
    |=> output_enable_ff [*8]) else $error("delay mode dropped early");
  a_latched_off: assert property (act_ff[7:3] == 5'h10 && !output_enable_ff && !alert_line_n_ff && !clear_faults
    && !req.wr |=> !output_enable_ff) else $error("restart without retries");
  a_cmd_off: assert property (!output_cmd_on |=> !output_enable_ff) else $error("output on while off");
  c_restart: cover property (act_ff[7:6] == 2'h2 && $rose(output_enable_ff));
  c_hold_end: cover property (act_ff[7:6] == 2'h3 && $fell(uc_fault));
  c_read: cover property (rd_valid_ff && rd_data_ff != 16'h0000);
endmodule // frs_chk
bind frs_fault_response_sequencer frs_chk #(.OPER_UNIT_CYC(OPER_UNIT_CYC), .RETRY_UNIT_CYC(RETRY_UNIT_CYC)) i_chk (
  .sys_clk(sys_clk), .sys_rst(sys_rst), .req(req), .rd_data_ff(rd_data_ff), .rd_valid_ff(rd_valid_ff),
  .clear_faults(clear_faults), .uc_fault(uc_fault), .temperature(temperature), .output_cmd_on(output_cmd_on),
  .output_enable_ff(output_enable_ff), .alert_line_n_ff(alert_line_n_ff));
`default_nettype wire

/* verif/frs_fault_response_sequencer_tb.sv */
// Self-checking bench for the fault response sequencer
`timescale 1ns/1ns
`default_nettype none
module frs_fault_response_sequencer_tb;
  localparam int OU = 10;
  localparam int RU = 8;
  logic sys_clk = 1'b0, sys_rst = 1'b1, clear_faults = 1'b0, uc_fault = 1'b0, output_cmd_on = 1'b0;
  logic [15:0] temperature = 16'h0000, rd_data_ff, thr;
  logic rd_valid_ff, oe, alert_n;
  frs_pkg::frs_req_s req;
  int n_fail, total_checks, seed, rises, off_len, on_len, dly, gap;
  int mdl [logic [7:0]];
  logic q [$];
  always #50 sys_clk = ~sys_clk;
  frs_host i_host (.sys_clk(sys_clk), .req(req), .rd_data_ff(rd_data_ff), .rd_valid_ff(rd_valid_ff));
  frs_fault_response_sequencer #(.OPER_UNIT_CYC(OU), .RETRY_UNIT_CYC(RU)) i_dut (.sys_clk(sys_clk),
    .sys_rst(sys_rst), .req(req), .rd_data_ff(rd_data_ff), .rd_valid_ff(rd_valid_ff), .clear_faults(clear_faults),
    .uc_fault(uc_fault), .temperature(temperature), .output_cmd_on(output_cmd_on), .output_enable_ff(oe),
    .alert_line_n_ff(alert_n));
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test;
    $display("%0d checks, %0d mismatches", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    logic [15:0] g;
    logic v;
    i_host.xfer(1'b1, c, d, g, v);
    if (mdl.exists(c)) mdl[c] = (c == frs_pkg::CMD_UC_ACTION) ? {8'h00, d[7:0]} : d;
  endtask
  task automatic rd_chk(input logic [7:0] c, input logic [15:0] e);
    logic [15:0] g;
    logic v;
    i_host.xfer(1'b0, c, 16'h0000, g, v);
    check({15'h0, v}, 16'h0001);
    check(g, e);
  endtask
  // Bounded wait for the output enable to reach a level
  task automatic wait_oe(input logic lvl, input int lim);
    while (lim > 0) begin
      @(negedge sys_clk);
      if (oe === lvl) break;
      lim--;
    end
    if (lim == 0) begin
      n_fail++;
      end_of_test();
    end
  endtask
  task automatic recover;
    @(posedge sys_clk);
    uc_fault <= 1'b0;
    clear_faults <= 1'b1;
    output_cmd_on <= 1'b1;
    @(posedge sys_clk);
    clear_faults <= 1'b0;
    wait_oe(1'b1, 100);
  endtask
  // Hold the fault n cycles; first high run, first off run, enable rises
  task automatic run_fault(input int n);
    int f;
    q.delete();
    @(posedge sys_clk);
    uc_fault <= 1'b1;
    repeat (n) begin
      @(negedge sys_clk);
      q.push_back(oe);
    end
    f = n;
    rises = 0;
    for (int i = n - 1; i >= 0; i--) if (q[i] === 1'b0) f = i;
    on_len = f;
    off_len = 0;
    for (int i = f; i < n && q[i] === 1'b0; i++) off_len++;
    gap = 0;
    for (int i = 1; i < n; i++) if (q[i] === 1'b1 && q[i-1] === 1'b0) begin
      rises++;
      if (rises == 1) gap = -i;
      if (rises == 2) gap += i;
    end
  endtask
  initial begin
    seed = 32'h524fc406;
    mdl[frs_pkg::CMD_UC_ACTION] = 0;
    mdl[frs_pkg::CMD_OT_THRESHOLD] = 0;
    repeat (5) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rd_chk(frs_pkg::CMD_UC_ACTION, 16'(mdl[frs_pkg::CMD_UC_ACTION]));
    rd_chk(8'h12, 16'h0000);
    thr = 16'($random(seed)) & 16'h3fff;
    wr(frs_pkg::CMD_OT_THRESHOLD, thr);
    rd_chk(frs_pkg::CMD_OT_THRESHOLD, 16'(mdl[frs_pkg::CMD_OT_THRESHOLD]));
    recover();
    @(posedge sys_clk);
    temperature <= thr + 16'h0001;
    repeat (3) @(negedge sys_clk);
    check({15'h0, alert_n}, 16'h0000);
    rd_chk(frs_pkg::CMD_STATUS, 16'h0002);
    @(posedge sys_clk);
    temperature <= 16'h0000;
    recover();
    check({15'h0, alert_n}, 16'h0001);
    $display("register and temperature test done");
    run_fault(50);
    check(16'(on_len), 16'd50);
    rd_chk(frs_pkg::CMD_STATUS, 16'h0001);
    recover();
    wr(frs_pkg::CMD_UC_ACTION, 16'h00c0);
    run_fault(20);
    check(16'(on_len), 16'd1);
    @(posedge sys_clk);
    uc_fault <= 1'b0;
    wait_oe(1'b1, 5);
    recover();
    wr(frs_pkg::CMD_UC_ACTION, 16'h0043);
    run_fault(60);
    check({15'h0, on_len >= 3 * OU && on_len <= 3 * OU + 3}, 16'h0001);
    recover();
    $display("mode test done");
    for (int r = 0; r < 8; r++) begin
      dly = 1 + int'($unsigned($random(seed)) % 3);
      wr(frs_pkg::CMD_UC_ACTION, 16'(8'h80 | (r << 3) | dly));
      run_fault((7 + 1) * (dly * RU + 2) + 20);
      check(16'(on_len), 16'd1);
      check({15'h0, r == 7 ? rises >= 6 : rises == r}, 16'h0001);
      if (r > 0) check(16'(off_len), 16'(dly * RU));
      if (r > 1) check(16'(gap), 16'(dly * RU));
      if (r < 7) check({15'h0, q[$]}, 16'h0000);
      @(posedge sys_clk);
      output_cmd_on <= 1'b0;
      repeat (3) @(negedge sys_clk);
      check({15'h0, oe}, 16'h0000);
      recover();
    end
    $display("retry test done");
    end_of_test();
  end
endmodule // frs_fault_response_sequencer_tb
`default_nettype wire

/* verif/frs_host.sv */
// Management host model issuing one command per call
`timescale 1ns/1ns
`default_nettype none
module frs_host (
  // Bus
  input  wire logic                sys_clk,
  output var frs_pkg::frs_req_s    req,
  input  wire logic [15:0]         rd_data_ff,
  input  wire logic                rd_valid_ff
);
  initial req = '0;
  task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d, output logic [15:0] g,
                      output logic v);
    @(posedge sys_clk);
    req <= '{wr: w, rd: !w, cmd: c, data: d};
    @(posedge sys_clk);
    req <= '{wr: 1'b0, rd: 1'b0, cmd: ~c, data: ~d};
    @(negedge sys_clk);
    g = rd_data_ff;
    v = rd_valid_ff;
  endtask
endmodule // frs_host
`default_nettype wire

/* verilog/frs_fault_response_sequencer.sv */
// Fault response sequencer: undercurrent action, over-temperature limit, alert
`timescale 1ns/1ns
`default_nettype none

module frs_fault_response_sequencer #(
  parameter int OPER_UNIT_CYC  = frs_pkg::OPER_UNIT_CYC,
  parameter int RETRY_UNIT_CYC = frs_pkg::RETRY_UNIT_CYC
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             sys_rst,
  // Management command port
  input  wire frs_pkg::frs_req_s req,
  output logic [15:0]           rd_data_ff,
  output logic                  rd_valid_ff,
  input  wire logic             clear_faults,
  // Power stage
  input  wire logic             uc_fault,
  input  wire logic [15:0]      temperature,
  input  wire logic             output_cmd_on,
  output logic                  output_enable_ff,
  // Alert
  output logic                  alert_line_n_ff
);

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  logic [7:0]  action_ff, nxt_action;
  logic [15:0] threshold_ff, nxt_threshold;
  logic [1:0]  status_ff, nxt_status;
  logic [15:0] nxt_rd_data;
  logic        nxt_rd_valid;
  logic        ot_fault;

  assign ot_fault = ($signed(temperature) > $signed(threshold_ff));

  always_comb begin
    nxt_action    = action_ff;
    nxt_threshold = threshold_ff;
    nxt_status    = status_ff;
    nxt_rd_data   = 16'h0000;
    nxt_rd_valid  = req.rd;
    if (clear_faults) begin
      nxt_status = 2'h0;
    end
    if (req.wr && req.cmd == frs_pkg::CMD_UC_ACTION) begin
      nxt_action = req.data[7:0];
    end else if (req.wr && req.cmd == frs_pkg::CMD_OT_THRESHOLD) begin
      nxt_threshold = req.data;
    end
    if (req.rd && req.cmd == frs_pkg::CMD_UC_ACTION) begin
      nxt_rd_data = {8'h00, action_ff};
    end else if (req.rd && req.cmd == frs_pkg::CMD_OT_THRESHOLD) begin
      nxt_rd_data = threshold_ff;
    end else if (req.rd && req.cmd == frs_pkg::CMD_STATUS) begin
      nxt_rd_data = {14'h0000, status_ff};
    end
    // Set wins over clear
    if (uc_fault) begin
      nxt_status[frs_pkg::STAT_UC_BIT] = 1'b1;
    end
    if (ot_fault) begin
      nxt_status[frs_pkg::STAT_OT_BIT] = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      action_ff    <= frs_pkg::ACTION_RST;
      threshold_ff <= frs_pkg::THRESHOLD_RST;
      status_ff    <= 2'h0;
      rd_data_ff   <= 16'h0000;
      rd_valid_ff  <= 1'b0;
    end else begin
      action_ff    <= nxt_action;
      threshold_ff <= nxt_threshold;
      status_ff    <= nxt_status;
      rd_data_ff   <= nxt_rd_data;
      rd_valid_ff  <= nxt_rd_valid;
    end
  end

  // ----------------------------------------
  // Response sequencer
  // ----------------------------------------
  frs_pkg::frs_state_e state_ff, nxt_state;
  logic [31:0] timer_ff, nxt_timer;
  logic [2:0]  units_ff, nxt_units;
  logic [2:0]  tries_ff, nxt_tries;
  logic        nxt_out_en;
  logic [1:0]  resp;
  logic [2:0]  retry_set;
  logic [2:0]  delay_cnt;
  logic        unit_done;

  assign resp      = action_ff[frs_pkg::RESP_HI:frs_pkg::RESP_LO];
  assign retry_set = action_ff[frs_pkg::RETRY_HI:frs_pkg::RETRY_LO];
  assign delay_cnt = action_ff[frs_pkg::DELAY_HI:frs_pkg::DELAY_LO];

  // Timer counts the cycles of one unit; units_ff counts elapsed units
  assign unit_done = (state_ff == frs_pkg::ST_DELAY)
                   ? (timer_ff == 32'(OPER_UNIT_CYC - 1))
                   : (timer_ff == 32'(RETRY_UNIT_CYC - 1));

  always_comb begin
    nxt_state  = state_ff;
    nxt_timer  = 32'h0000_0000;
    nxt_units  = 3'h0;
    nxt_tries  = tries_ff;
    nxt_out_en = output_cmd_on;
    case (state_ff)
      frs_pkg::ST_RUN: begin
        nxt_tries = 3'h0;
        if (uc_fault) begin
          if (resp == frs_pkg::RESP_IGNORE) begin
            nxt_state = frs_pkg::ST_RUN;
          end else if (resp == frs_pkg::RESP_DELAYED) begin
            nxt_state = frs_pkg::ST_DELAY;
          end else if (resp == frs_pkg::RESP_RETRY) begin
            nxt_out_en = 1'b0;
            nxt_state  = (retry_set == frs_pkg::RETRY_NONE) ? frs_pkg::ST_LATCHED : frs_pkg::ST_OFF_WAIT;
          end else begin
            nxt_out_en = 1'b0;
            nxt_state  = frs_pkg::ST_HOLD;
          end
        end
      end
      frs_pkg::ST_DELAY: begin
        nxt_timer = unit_done ? 32'h0000_0000 : timer_ff + 32'h1;
        nxt_units = unit_done ? units_ff + 3'h1 : units_ff;
        if (!uc_fault) begin
          nxt_state = frs_pkg::ST_RUN;
        end else if (units_ff == delay_cnt) begin
          nxt_out_en = 1'b0;
          nxt_state  = (retry_set == frs_pkg::RETRY_NONE) ? frs_pkg::ST_LATCHED : frs_pkg::ST_OFF_WAIT;
          // Restart interval counts from zero in its own unit
          nxt_timer  = 32'h0000_0000;
          nxt_units  = 3'h0;
        end
      end
      frs_pkg::ST_OFF_WAIT: begin
        nxt_out_en = 1'b0;
        nxt_timer  = unit_done ? 32'h0000_0000 : timer_ff + 32'h1;
        nxt_units  = unit_done ? units_ff + 3'h1 : units_ff;
        if (nxt_units == delay_cnt) begin
          nxt_state = frs_pkg::ST_RESTART;
          nxt_out_en = output_cmd_on;
          nxt_timer  = 32'h0000_0000;
          nxt_units  = 3'h0;
          if (retry_set != frs_pkg::RETRY_FOREVER) begin
            nxt_tries = tries_ff + 3'h1;
          end
        end
      end
      frs_pkg::ST_RESTART: begin
        // Restart attempt: fault back means the attempt failed
        if (uc_fault) begin
          nxt_out_en = 1'b0;
          // Attempt cycle is the first cycle of the next interval
          nxt_timer  = unit_done ? 32'h0000_0000 : timer_ff + 32'h1;
          nxt_units  = unit_done ? units_ff + 3'h1 : units_ff;
          if (retry_set == frs_pkg::RETRY_FOREVER) begin
            nxt_state = frs_pkg::ST_OFF_WAIT;
          end else if (tries_ff >= retry_set) begin
            nxt_state = frs_pkg::ST_LATCHED;
          end else begin
            nxt_state = frs_pkg::ST_OFF_WAIT;
          end
        end else begin
          nxt_state = frs_pkg::ST_RUN;
        end
        if (!output_cmd_on) begin
          nxt_state = frs_pkg::ST_RUN;
        end
      end
      frs_pkg::ST_LATCHED: begin
        nxt_out_en = 1'b0;
        if (clear_faults) begin
          nxt_state = frs_pkg::ST_RUN;
        end
      end
      frs_pkg::ST_HOLD: begin
        nxt_out_en = 1'b0;
        if (!uc_fault) begin
          nxt_out_en = output_cmd_on;
          nxt_state  = frs_pkg::ST_RUN;
        end
      end
      default: begin
        nxt_state = frs_pkg::ST_RUN;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_ff         <= frs_pkg::ST_RUN;
      timer_ff         <= 32'h0000_0000;
      units_ff         <= 3'h0;
      tries_ff         <= 3'h0;
      output_enable_ff <= 1'b0;
      alert_line_n_ff  <= 1'b1;
    end else begin
      state_ff         <= nxt_state;
      timer_ff         <= nxt_timer;
      units_ff         <= nxt_units;
      tries_ff         <= nxt_tries;
      output_enable_ff <= nxt_out_en;
      alert_line_n_ff  <= ~(|nxt_status);
    end
  end

endmodule // frs_fault_response_sequencer

`default_nettype wire

/* verilog/frs_pkg.sv */
// Package for the fault response sequencer: command codes, fields, timing
`default_nettype none
package frs_pkg;

  // ----------------------------------------
  // Command codes
  // ----------------------------------------
  localparam logic [7:0] CMD_UC_ACTION    = 8'h4c;
  localparam logic [7:0] CMD_OT_THRESHOLD = 8'h4f;
  localparam logic [7:0] CMD_STATUS       = 8'he0;

  // ----------------------------------------
  // Action field layout and encodings
  // ----------------------------------------
  localparam int RESP_HI  = 7;
  localparam int RESP_LO  = 6;
  localparam int RETRY_HI = 5;
  localparam int RETRY_LO = 3;
  localparam int DELAY_HI = 2;
  localparam int DELAY_LO = 0;

  localparam logic [1:0] RESP_IGNORE  = 2'h0;
  localparam logic [1:0] RESP_DELAYED = 2'h1;
  localparam logic [1:0] RESP_RETRY   = 2'h2;
  localparam logic [1:0] RESP_HOLD    = 2'h3;
  localparam logic [2:0] RETRY_NONE   = 3'h0;
  localparam logic [2:0] RETRY_FOREVER = 3'h7;

  // ----------------------------------------
  // Reset values and status bit positions
  // ----------------------------------------
  localparam logic [7:0]  ACTION_RST    = 8'h00;
  localparam logic [15:0] THRESHOLD_RST = 16'h0000;
  localparam int STAT_UC_BIT = 0;
  localparam int STAT_OT_BIT = 1;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_HZ        = 10_000_000;
  localparam int OPER_UNIT_US  = 10_000;
  localparam int RETRY_UNIT_US = 8_200;
  localparam int OPER_UNIT_CYC  = (OPER_UNIT_US / 1000) * (CLK_HZ / 1000);
  localparam int RETRY_UNIT_CYC = (RETRY_UNIT_US * (CLK_HZ / 1000)) / 1000;

  typedef enum logic [2:0] {
    ST_RUN     = 3'b000,
    ST_DELAY   = 3'b001,
    ST_OFF_WAIT = 3'b010,
    ST_RESTART = 3'b011,
    ST_LATCHED = 3'b100,
    ST_HOLD    = 3'b101
  } frs_state_e;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] cmd;
    logic [15:0] data;
  } frs_req_s;

endpackage : frs_pkg

`default_nettype wire
